// *** hw/uic_counter.sv ***
module uic_counter #(
	parameter int unsigned W = 16
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic en_i,
	input wire logic step_i,
	input wire logic down_i,
	input wire logic load_i,
	input wire logic [W-1:0] load_val_i,
	output logic [W-1:0] count_o,
	output logic hit_o
);
	typedef struct packed {
		logic [W-1:0] cnt;
		logic [W-1:0] lim;
		logic hit;
	} uic_cnt_s;

	uic_cnt_s state_q;
	uic_cnt_s state_d;

	// ==========================================
	// Up wraps after the limit, down reloads the start after zero
	always_comb begin
		state_d = state_q;
		state_d.hit = 1'b0;
		if (load_i) begin
			state_d.lim = load_val_i;
			state_d.cnt = down_i ? load_val_i : '0;
		end else if (en_i && step_i) begin
			if (down_i) begin
				state_d.cnt = (state_q.cnt == '0) ? state_q.lim
					: state_q.cnt - 1'b1;
				state_d.hit = (state_d.cnt == '0);
			end else begin
				state_d.cnt = (state_q.cnt == state_q.lim) ? '0
					: state_q.cnt + 1'b1;
				state_d.hit = (state_d.cnt == state_q.lim);
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	assign count_o = state_q.cnt;
	assign hit_o = state_q.hit;

	// ==========================================
	// Checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	property p_up_hit;
		en_i && step_i && !load_i && !down_i
			&& state_q.cnt + 1'b1 == state_q.lim
			|=> hit_o && count_o == $past(state_q.lim);
	endproperty
	a_up_hit: assert property (p_up_hit)
		else $error("up counter missed its limit event");

	property p_down_hit;
		en_i && step_i && !load_i && down_i && state_q.cnt == W'(1)
			|=> hit_o && count_o == '0;
	endproperty
	a_down_hit: assert property (p_down_hit)
		else $error("down counter missed its zero event");
endmodule : uic_counter

// *** hw/uic_pkg.sv ***
package uic_pkg;
	// ==========================================
	// Sizes
	localparam int unsigned NUM_IN = 4;
	localparam int unsigned NUM_CNT = 3;
	localparam int unsigned NUM_PINS = 7;
	localparam int unsigned GATE_LSB = 4;
	localparam int unsigned CNT12_W = 16;
	localparam int unsigned CNT3_W = 24;
	localparam int unsigned ADDR_W = 4;
	localparam int unsigned DATA_W = 32;
	// ==========================================
	// Register map (word addresses)
	localparam logic [3:0] ADR_CTRL = 4'h0;
	localparam logic [3:0] ADR_MODE = 4'h1;
	localparam logic [3:0] ADR_LOAD1 = 4'h2;
	localparam logic [3:0] ADR_LOAD2 = 4'h3;
	localparam logic [3:0] ADR_LOAD3 = 4'h4;
	localparam logic [3:0] ADR_COUNT1 = 4'h5;
	localparam logic [3:0] ADR_COUNT2 = 4'h6;
	localparam logic [3:0] ADR_COUNT3 = 4'h7;
	localparam logic [3:0] ADR_STATUS = 4'h8;
	localparam logic [3:0] ADR_GATE = 4'h9;
	localparam logic [3:0] ADR_ISTAT = 4'ha;
	localparam logic [3:0] ADR_IMASK = 4'hb;
	// ==========================================
	// Field layouts
	localparam int unsigned CTRL_EN_LSB = 0;
	localparam int unsigned CTRL_LOAD_LSB = 4;
	localparam int unsigned MODE_FLD_W = 8;
	localparam int unsigned MODE_EDGE_BIT = 3;
	localparam int unsigned MODE_DIR_BIT = 4;
	localparam int unsigned ST_IN_LSB = 0;
	localparam int unsigned ST_EN_LSB = 4;
	localparam int unsigned IS_IN_LSB = 0;
	localparam int unsigned IS_CNT_LSB = 4;
	localparam int unsigned IS_MEAS_BIT = 7;
	localparam int unsigned ISTAT_W = 8;
	localparam int unsigned GSEL_W = 2;
	typedef enum logic [2:0] {
		UIC_DIG, UIC_IRQ, UIC_CNT, UIC_GATED, UIC_FREQ, UIC_PERIOD
	} uic_mode_e;
	// ==========================================
	// Timing
	localparam int unsigned CLK_NS = 8;
	localparam int unsigned TB_NS = 1000;
	localparam int unsigned TB_CYCLES = (TB_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned TB_W = 7;
	localparam int unsigned GATE0_MS = 100;
	localparam int unsigned GATE1_MS = 1000;
	localparam int unsigned GATE2_MS = 10000;
	localparam int unsigned MS_NS = 1000000;
endpackage : uic_pkg

// *** hw/uic_sync.sv ***
module uic_sync #(
	parameter int unsigned W = 7
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [W-1:0] pins_i,
	output logic [W-1:0] level_o,
	output logic [W-1:0] rise_o,
	output logic [W-1:0] fall_o
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stab;
		logic [W-1:0] prev;
	} uic_sync_s;

	uic_sync_s state_q;
	uic_sync_s state_d;

	// ==========================================
	// Two-flop synchroniser, then edge detect
	always_comb begin
		state_d = state_q;
		state_d.meta = pins_i;
		state_d.stab = state_q.meta;
		state_d.prev = state_q.stab;
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	assign level_o = state_q.stab;
	assign rise_o = state_q.stab & ~state_q.prev;
	assign fall_o = ~state_q.stab & state_q.prev;
endmodule : uic_sync

// *** hw/uic_universal_inputs.sv ***
module uic_universal_inputs #(
	parameter int unsigned GATE0_TICKS =
		uic_pkg::GATE0_MS * (uic_pkg::MS_NS / uic_pkg::TB_NS),
	parameter int unsigned GATE1_TICKS =
		uic_pkg::GATE1_MS * (uic_pkg::MS_NS / uic_pkg::TB_NS),
	parameter int unsigned GATE2_TICKS =
		uic_pkg::GATE2_MS * (uic_pkg::MS_NS / uic_pkg::TB_NS)
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic uni_input_one_i,
	input wire logic uni_input_two_i,
	input wire logic uni_input_three_i,
	input wire logic uni_input_four_i,
	input wire logic gate_one_i,
	input wire logic gate_two_i,
	input wire logic gate_three_i,
	input wire logic [uic_pkg::ADDR_W-1:0] addr_i,
	input wire logic [uic_pkg::DATA_W-1:0] wr_data_i,
	input wire logic wr_en_i,
	input wire logic rd_en_i,
	output logic [uic_pkg::DATA_W-1:0] rd_data_o,
	output logic irq_o
);
	localparam int unsigned W3 = uic_pkg::CNT3_W;

	typedef struct packed {
		logic [uic_pkg::NUM_CNT-1:0] en;
		logic [uic_pkg::NUM_CNT-1:0] load;
		logic [uic_pkg::NUM_IN*uic_pkg::MODE_FLD_W-1:0] mode;
		logic [uic_pkg::CNT12_W-1:0] lv1;
		logic [uic_pkg::CNT12_W-1:0] lv2;
		logic [W3-1:0] lv3;
		logic [uic_pkg::GSEL_W-1:0] gsel;
		logic [uic_pkg::ISTAT_W-1:0] istat;
		logic [uic_pkg::ISTAT_W-1:0] imask;
		logic [W3-1:0] meas;
		logic [W3-1:0] mcnt;
		logic [W3-1:0] gtmr;
		logic [uic_pkg::TB_W-1:0] tb;
		logic irq;
		logic [uic_pkg::DATA_W-1:0] rdata;
	} uic_top_s;

	uic_top_s state_q;
	uic_top_s state_d;

	// ==========================================
	// Mode decode
	// Modes an input lacks fall back to plain digital input
	function automatic uic_pkg::uic_mode_e eff_mode(
		input int unsigned idx,
		input logic [uic_pkg::MODE_FLD_W-1:0] fld
	);
		uic_pkg::uic_mode_e m;
		m = uic_pkg::uic_mode_e'(fld[2:0]);
		case (m)
			uic_pkg::UIC_IRQ: eff_mode = m;
			uic_pkg::UIC_CNT, uic_pkg::UIC_GATED:
				eff_mode = (idx < uic_pkg::NUM_CNT) ? m
					: uic_pkg::UIC_DIG;
			uic_pkg::UIC_FREQ, uic_pkg::UIC_PERIOD:
				eff_mode = (idx == uic_pkg::NUM_CNT - 1) ? m
					: uic_pkg::UIC_DIG;
			default: eff_mode = uic_pkg::UIC_DIG;
		endcase
	endfunction : eff_mode

	function automatic logic [W3-1:0] gate_len(
		input logic [uic_pkg::GSEL_W-1:0] sel
	);
		case (sel)
			2'h0: gate_len = W3'(GATE0_TICKS);
			2'h1: gate_len = W3'(GATE1_TICKS);
			default: gate_len = W3'(GATE2_TICKS);
		endcase
	endfunction : gate_len

	// ==========================================
	// Pin synchronisation; field pulses at 10 kHz are far below clk
	logic [uic_pkg::NUM_PINS-1:0] lvl;
	logic [uic_pkg::NUM_PINS-1:0] rise;
	logic [uic_pkg::NUM_PINS-1:0] fall;

	uic_sync #(
		.W(uic_pkg::NUM_PINS)
	) u_sync (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.pins_i({gate_three_i, gate_two_i, gate_one_i, uni_input_four_i,
			uni_input_three_i, uni_input_two_i, uni_input_one_i}),
		.level_o(lvl),
		.rise_o(rise),
		.fall_o(fall)
	);

	uic_pkg::uic_mode_e mode [uic_pkg::NUM_IN];
	logic [uic_pkg::NUM_IN-1:0] ev;
	logic [uic_pkg::NUM_CNT-1:0] step;
	logic [uic_pkg::NUM_CNT-1:0] down;
	logic [uic_pkg::NUM_CNT-1:0] hit;
	logic [uic_pkg::CNT12_W-1:0] cnt1;
	logic [uic_pkg::CNT12_W-1:0] cnt2;
	logic [W3-1:0] cnt3;

	always_comb begin
		for (int i = 0; i < uic_pkg::NUM_IN; i++) begin
			mode[i] = eff_mode(i, state_q.mode[i*uic_pkg::MODE_FLD_W +:
				uic_pkg::MODE_FLD_W]);
			ev[i] = state_q.mode[i*uic_pkg::MODE_FLD_W
				+ uic_pkg::MODE_EDGE_BIT] ? fall[i] : rise[i];
		end
		for (int i = 0; i < uic_pkg::NUM_CNT; i++) begin
			down[i] = state_q.mode[i*uic_pkg::MODE_FLD_W
				+ uic_pkg::MODE_DIR_BIT];
			step[i] = ev[i] && (mode[i] == uic_pkg::UIC_CNT
				|| (mode[i] == uic_pkg::UIC_GATED
				&& lvl[uic_pkg::GATE_LSB + i]));
		end
	end

	// ==========================================
	// Pulse counters
	uic_counter #(.W(uic_pkg::CNT12_W)) u_cnt_one (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .en_i(state_q.en[0]),
		.step_i(step[0]), .down_i(down[0]), .load_i(state_q.load[0]),
		.load_val_i(state_q.lv1), .count_o(cnt1), .hit_o(hit[0])
	);
	uic_counter #(.W(uic_pkg::CNT12_W)) u_cnt_two (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .en_i(state_q.en[1]),
		.step_i(step[1]), .down_i(down[1]), .load_i(state_q.load[1]),
		.load_val_i(state_q.lv2), .count_o(cnt2), .hit_o(hit[1])
	);
	uic_counter #(.W(W3)) u_cnt_three (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .en_i(state_q.en[2]),
		.step_i(step[2]), .down_i(down[2]), .load_i(state_q.load[2]),
		.load_val_i(state_q.lv3), .count_o(cnt3), .hit_o(hit[2])
	);

	// ==========================================
	// Registers, measurement and interrupts
	logic tick;
	logic [uic_pkg::ISTAT_W-1:0] set;
	logic [uic_pkg::ISTAT_W-1:0] clr;
	logic [W3-1:0] cnt3_rd;

	always_comb begin
		state_d = state_q;
		state_d.load = '0;
		state_d.rdata = '0;
		set = '0;
		clr = '0;
		tick = (state_q.tb == uic_pkg::TB_W'(uic_pkg::TB_CYCLES - 1));
		state_d.tb = tick ? '0 : state_q.tb + 1'b1;
		for (int i = 0; i < uic_pkg::NUM_IN; i++) begin
			if (mode[i] == uic_pkg::UIC_IRQ && ev[i]) begin
				set[uic_pkg::IS_IN_LSB + i] = 1'b1;
			end
		end
		set[uic_pkg::IS_CNT_LSB +: uic_pkg::NUM_CNT] = hit;
		if (!state_q.en[2]) begin
			state_d.mcnt = '0;
			state_d.gtmr = '0;
		end else if (mode[2] == uic_pkg::UIC_FREQ) begin
			state_d.mcnt = state_q.mcnt + W3'(ev[2]);
			if (tick) begin
				if (state_q.gtmr == gate_len(state_q.gsel) - 1'b1) begin
					state_d.meas = state_d.mcnt;
					state_d.mcnt = '0;
					state_d.gtmr = '0;
					set[uic_pkg::IS_MEAS_BIT] = 1'b1;
				end else begin
					state_d.gtmr = state_q.gtmr + 1'b1;
				end
			end
		end else if (mode[2] == uic_pkg::UIC_PERIOD) begin
			if (rise[2]) begin
				state_d.meas = state_q.mcnt + W3'(tick);
				state_d.mcnt = '0;
				set[uic_pkg::IS_MEAS_BIT] = 1'b1;
			end else if (tick) begin
				state_d.mcnt = state_q.mcnt + 1'b1;
			end
		end else begin
			state_d.mcnt = '0;
			state_d.gtmr = '0;
		end
		if (wr_en_i) begin
			case (addr_i)
				uic_pkg::ADR_CTRL: begin
					state_d.en = wr_data_i[uic_pkg::CTRL_EN_LSB +:
						uic_pkg::NUM_CNT];
					state_d.load = wr_data_i[uic_pkg::CTRL_LOAD_LSB +:
						uic_pkg::NUM_CNT];
				end
				uic_pkg::ADR_MODE: state_d.mode = wr_data_i;
				uic_pkg::ADR_LOAD1:
					state_d.lv1 = wr_data_i[uic_pkg::CNT12_W-1:0];
				uic_pkg::ADR_LOAD2:
					state_d.lv2 = wr_data_i[uic_pkg::CNT12_W-1:0];
				uic_pkg::ADR_LOAD3: state_d.lv3 = wr_data_i[W3-1:0];
				uic_pkg::ADR_GATE:
					state_d.gsel = wr_data_i[uic_pkg::GSEL_W-1:0];
				uic_pkg::ADR_ISTAT:
					clr = wr_data_i[uic_pkg::ISTAT_W-1:0];
				uic_pkg::ADR_IMASK:
					state_d.imask = wr_data_i[uic_pkg::ISTAT_W-1:0];
				default: ;
			endcase
		end
		// A new event beats a clear in the same cycle
		state_d.istat = (state_q.istat & ~clr) | set;
		state_d.irq = |(state_q.istat & state_q.imask);
		cnt3_rd = (mode[2] == uic_pkg::UIC_FREQ
			|| mode[2] == uic_pkg::UIC_PERIOD) ? state_q.meas : cnt3;
		if (rd_en_i) begin
			case (addr_i)
				uic_pkg::ADR_CTRL: state_d.rdata = 32'(state_q.en);
				uic_pkg::ADR_MODE: state_d.rdata = state_q.mode;
				uic_pkg::ADR_LOAD1: state_d.rdata = 32'(state_q.lv1);
				uic_pkg::ADR_LOAD2: state_d.rdata = 32'(state_q.lv2);
				uic_pkg::ADR_LOAD3: state_d.rdata = 32'(state_q.lv3);
				uic_pkg::ADR_COUNT1: state_d.rdata = 32'(cnt1);
				uic_pkg::ADR_COUNT2: state_d.rdata = 32'(cnt2);
				uic_pkg::ADR_COUNT3: state_d.rdata = 32'(cnt3_rd);
				uic_pkg::ADR_STATUS: begin
					state_d.rdata[uic_pkg::ST_IN_LSB +: uic_pkg::NUM_IN] =
						lvl[uic_pkg::NUM_IN-1:0];
					state_d.rdata[uic_pkg::ST_EN_LSB +: uic_pkg::NUM_CNT] =
						state_q.en;
				end
				uic_pkg::ADR_GATE: state_d.rdata = 32'(state_q.gsel);
				uic_pkg::ADR_ISTAT: state_d.rdata = 32'(state_q.istat);
				uic_pkg::ADR_IMASK: state_d.rdata = 32'(state_q.imask);
				default: state_d.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	assign rd_data_o = state_q.rdata;
	assign irq_o = state_q.irq;

	// ==========================================
	// Checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	sequence s_irq_edge;
		mode[0] == uic_pkg::UIC_IRQ && ev[0];
	endsequence
	property p_irq_edge;
		s_irq_edge |=> state_q.istat[uic_pkg::IS_IN_LSB] ##1 irq_o
			|| !state_q.imask[uic_pkg::IS_IN_LSB];
	endproperty
	a_irq_edge: assert property (p_irq_edge)
		else $error("interrupt edge not flagged");

	property p_dig_quiet;
		mode[0] == uic_pkg::UIC_DIG && !state_q.istat[uic_pkg::IS_IN_LSB]
			|=> !state_q.istat[uic_pkg::IS_IN_LSB];
	endproperty
	a_dig_quiet: assert property (p_dig_quiet)
		else $error("digital input raised an interrupt");

	property p_status;
		rd_en_i && addr_i == uic_pkg::ADR_STATUS |=>
			rd_data_o[uic_pkg::NUM_IN-1:0] == $past(lvl[uic_pkg::NUM_IN-1:0])
			&& rd_data_o[uic_pkg::ST_EN_LSB +: uic_pkg::NUM_CNT]
			== $past(state_q.en);
	endproperty
	a_status: assert property (p_status)
		else $error("status byte wrong");

	property p_hold;
		!state_q.en[0] && !state_q.load[0] |=> $stable(cnt1);
	endproperty
	a_hold: assert property (p_hold)
		else $error("disabled counter moved");

	property p_gate_closed;
		mode[1] == uic_pkg::UIC_GATED && !lvl[uic_pkg::GATE_LSB + 1]
			&& !state_q.load[1] |=> $stable(cnt2);
	endproperty
	a_gate_closed: assert property (p_gate_closed)
		else $error("gated counter moved with gate closed");

	sequence s_period_edge;
		state_q.en[2] && mode[2] == uic_pkg::UIC_PERIOD && rise[2];
	endsequence
	property p_period;
		s_period_edge |=> state_q.meas == $past(state_q.mcnt)
			+ W3'($past(tick)) && state_q.mcnt == '0;
	endproperty
	a_period: assert property (p_period)
		else $error("period result not captured");

	property p_load_down;
		state_q.load[1] && down[1] |=> cnt2 == $past(state_q.lv2);
	endproperty
	a_load_down: assert property (p_load_down)
		else $error("down counter did not take start value");

	property p_no_cnt_four;
		mode[3] == uic_pkg::UIC_DIG || mode[3] == uic_pkg::UIC_IRQ;
	endproperty
	a_no_cnt_four: assert property (p_no_cnt_four)
		else $error("input four in a counting mode");

	property p_up_step;
		step[0] && state_q.en[0] && !down[0] && !state_q.load[0]
			&& cnt1 != state_q.lv1 |=> cnt1 == $past(cnt1) + 1'b1;
	endproperty
	a_up_step: assert property (p_up_step)
		else $error("up counter missed a pulse");
endmodule : uic_universal_inputs

// *** verification/uic_field_src.sv ***
// ==========================================
// Field pulse sources on the four inputs and three gate pins
module uic_field_src (
	input wire logic clk_i,
	input wire logic [6:0] lvl_i,
	input wire logic [6:0] pulse_i,
	input wire logic run_i,
	output logic [6:0] pins_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] hi_q [7];
	logic [7:0] sq_q;
	logic [6:0] pl;
	initial sq_q = 8'h00;
	initial for (int k = 0; k < 7; k++) hi_q[k] = 2'h0;
	// Pulses stay high three clocks, above the two the synchroniser needs
	always @(posedge clk_i) begin
		for (int k = 0; k < 7; k++) begin
			if (pulse_i[k]) begin
				hi_q[k] <= 2'h3;
			end else if (hi_q[k] != 2'h0) begin
				hi_q[k] <= hi_q[k] - 2'h1;
			end
		end
		sq_q <= (sq_q == 8'hf9) ? 8'h00 : sq_q + 8'h01;
	end
	always_comb begin
		for (int k = 0; k < 7; k++) pl[k] = (hi_q[k] != 2'h0);
	end
	// Free-running square wave of 250 clocks on input three
	assign pins_o = lvl_i ^ pl ^ {4'h0, run_i & (sq_q < 8'h7d), 2'h0};
endmodule : uic_field_src

// *** verification/universal_input_counters_tb.sv ***
module universal_input_counters_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [31:0] wdata = 32'h0;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic [6:0] lvl = 7'h0;
	logic [6:0] pls = 7'h0;
	logic run = 1'b0;
	logic [6:0] pins;
	logic [31:0] rd_data_o;
	logic irq_o;
	logic [31:0] d;
	logic [15:0] r = 16'h000f;
	logic [15:0] lim;
	int failures = 0;
	int n_tests = 0;
	int cyc = 0;
	always #4 clk_i = ~clk_i;
	uic_field_src i_src (.clk_i(clk_i), .lvl_i(lvl), .pulse_i(pls),
		.run_i(run), .pins_o(pins));
	uic_universal_inputs #(.GATE0_TICKS(10), .GATE1_TICKS(20),
		.GATE2_TICKS(30)) i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.uni_input_one_i(pins[0]), .uni_input_two_i(pins[1]),
		.uni_input_three_i(pins[2]), .uni_input_four_i(pins[3]),
		.gate_one_i(pins[4]), .gate_two_i(pins[5]),
		.gate_three_i(pins[6]), .addr_i(addr), .wr_data_i(wdata),
		.wr_en_i(wr_en), .rd_en_i(rd_en), .rd_data_o(rd_data_o),
		.irq_o(irq_o));
	// ==========================================
	// Expectations and random source
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr
	function automatic logic [31:0] exp_up(input int l, input int n);
		return n % (l + 1);
	endfunction : exp_up
	function automatic logic [31:0] exp_dn(input int s, input int n);
		return s - (n % (s + 1));
	endfunction : exp_dn
	// ==========================================
	// Bus, pins and reporting
	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge clk_i);
		addr <= a;
		wdata <= v;
		wr_en <= 1'b1;
		@(posedge clk_i);
		wr_en <= 1'b0;
	endtask : wr
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// Read data stand for one cycle only; take them mid-cycle
	task automatic rd(input logic [3:0] a);
		@(posedge clk_i);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk_i);
		rd_en <= 1'b0;
		@(negedge clk_i);
		d = rd_data_o;
	endtask : rd
	task automatic rchk(input string nm, input logic [3:0] a,
		input logic [31:0] e);
		rd(a);
		chk(nm, e, d);
	endtask : rchk
	task automatic pulse(input logic [6:0] m);
		@(posedge clk_i);
		pls <= m;
		@(posedge clk_i);
		pls <= 7'h0;
		repeat (6) @(posedge clk_i);
	endtask : pulse
	task automatic test_done();
		$display("checks %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : test_done
	// Ceiling well above the few thousand clocks the tests need
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			failures++;
			test_done();
		end
	end
	// ==========================================
	// Main sequence
	initial begin
		repeat (3) @(posedge clk_i);
		rst_n_i <= 1'b1;
		rchk("ctrl", uic_pkg::ADR_CTRL, 32'h0);
		rchk("istat", uic_pkg::ADR_ISTAT, 32'h0);
		rchk("status", uic_pkg::ADR_STATUS, 32'h0);
		rchk("unmapped", 4'hf, 32'h0);
		chk("irq", 32'h0, {31'h0, irq_o});
		$display("test reset done");
		// Digital: levels only visible on read, no event
		r = lfsr(r);
		@(posedge clk_i);
		lvl <= {3'h0, r[3:0]};
		repeat (5) @(posedge clk_i);
		rchk("levels", uic_pkg::ADR_STATUS, {28'h0, r[3:0]});
		rchk("dig istat", uic_pkg::ADR_ISTAT, 32'h0);
		@(posedge clk_i);
		lvl <= 7'h0;
		repeat (5) @(posedge clk_i);
		$display("test digital done");
		// Interrupt: input one rising, input four falling
		wr(uic_pkg::ADR_MODE, 32'h09000001);
		wr(uic_pkg::ADR_IMASK, 32'h09);
		pulse(7'h01);
		@(negedge clk_i);
		chk("irq one", 32'h1, {31'h0, irq_o});
		pulse(7'h08);
		rchk("irq edges", uic_pkg::ADR_ISTAT, 32'h09);
		wr(uic_pkg::ADR_IMASK, 32'h0);
		repeat (2) @(negedge clk_i);
		chk("irq masked", 32'h0, {31'h0, irq_o});
		wr(uic_pkg::ADR_ISTAT, 32'h09);
		rchk("istat clr", uic_pkg::ADR_ISTAT, 32'h0);
		$display("test interrupt done");
		// Up on one, down on two's falling edge, input four acts digital
		r = lfsr(r);
		lim = {14'h0, r[1:0]} + 16'h2;
		wr(uic_pkg::ADR_MODE, 32'h02001a02);
		wr(uic_pkg::ADR_LOAD1, {16'h0, lim});
		wr(uic_pkg::ADR_LOAD2, {16'h0, lim});
		wr(uic_pkg::ADR_CTRL, 32'h33);
		rchk("enables", uic_pkg::ADR_STATUS, 32'h30);
		for (int n = 1; n <= lim; n++) begin
			pulse(7'h0b);
			rchk("up", uic_pkg::ADR_COUNT1, exp_up(lim, n));
			rchk("down", uic_pkg::ADR_COUNT2, exp_dn(lim, n));
		end
		rchk("hits", uic_pkg::ADR_ISTAT, 32'h30);
		pulse(7'h03);
		rchk("wrap", uic_pkg::ADR_COUNT1, exp_up(lim, lim + 1));
		rchk("reload", uic_pkg::ADR_COUNT2, exp_dn(lim, lim + 1));
		wr(uic_pkg::ADR_CTRL, 32'h0);
		pulse(7'h03);
		rchk("hold1", uic_pkg::ADR_COUNT1, 32'h0);
		rchk("hold2", uic_pkg::ADR_COUNT2, {16'h0, lim});
		$display("test counters done");
		// Gated down counter on input three, full 24-bit start
		// Input two gated too, with its gate shut throughout
		wr(uic_pkg::ADR_MODE, 32'h00130300);
		wr(uic_pkg::ADR_LOAD3, 32'hffffff);
		wr(uic_pkg::ADR_CTRL, 32'h44);
		lvl <= 7'h10;
		pulse(7'h04);
		rchk("gate shut", uic_pkg::ADR_COUNT3, 32'hffffff);
		@(posedge clk_i);
		lvl <= 7'h40;
		repeat (4) @(posedge clk_i);
		pulse(7'h04);
		pulse(7'h04);
		rchk("gate open", uic_pkg::ADR_COUNT3, 32'hfffffd);
		@(posedge clk_i);
		lvl <= 7'h0;
		repeat (4) @(posedge clk_i);
		pulse(7'h04);
		rchk("gate closed", uic_pkg::ADR_COUNT3, 32'hfffffd);
		$display("test gated done");
		// Period: rising edges 625 clocks apart, five 1 us ticks
		wr(uic_pkg::ADR_MODE, 32'h00050000);
		wr(uic_pkg::ADR_CTRL, 32'h04);
		for (int k = 0; k < 3; k++) begin
			@(posedge clk_i);
			pls <= 7'h04;
			@(posedge clk_i);
			pls <= 7'h0;
			repeat (623) @(posedge clk_i);
		end
		rchk("period", uic_pkg::ADR_COUNT3, 32'h5);
		$display("test period done");
		// Frequency: 250-clock wave over a 10 us gate gives about 5
		wr(uic_pkg::ADR_GATE, 32'h2);
		rchk("gate sel", uic_pkg::ADR_GATE, 32'h2);
		wr(uic_pkg::ADR_GATE, 32'h0);
		wr(uic_pkg::ADR_MODE, 32'h00040000);
		run <= 1'b1;
		// The first window is partial, the second is a full gate
		for (int p = 0; p < 2; p++) begin
			wr(uic_pkg::ADR_ISTAT, 32'h80);
			d = 32'h0;
			for (int w = 0; w < 2000 && d[7] !== 1'b1; w++) begin
				rd(uic_pkg::ADR_ISTAT);
			end
			chk("ready", 32'h1, {31'h0, d[7]});
		end
		rd(uic_pkg::ADR_COUNT3);
		n_tests++;
		if ((d >= 32'h4 && d <= 32'h6) !== 1'b1) begin
			failures++;
			$display("[FAIL] freq expected 4..6 seen %h", d);
		end
		@(posedge clk_i);
		run <= 1'b0;
		$display("test frequency done");
		test_done();
	end
endmodule : universal_input_counters_tb
